// *** hdl/ticc_top.sv ***
// Conditioning of the two counter-driven interrupt channels and the merged request.
// Assumes counter outputs and port pin are synchronous to mclk; channels 0 and 1
// arrive already conditioned from the port-pin logic outside this block.
`timescale 1ns/1ps
`default_nettype none
module ticc_top (
	// Board clock and synchronous reset
	input wire logic mclk,
	input wire logic rst_b,
	// Pin and control bits, all static levels from the host side
	input wire logic port_c_bit0, // Port C bit 0 of the second port group
	input wire logic cnt0_input_polarity_sel, // 1 complements the counter-0 input
	input wire logic cnt1_clock_sel, // 0 picks 2 MHz, 1 picks 32768 Hz
	input wire logic chan2_mask_enable, // 1 lets channel 2 through
	input wire logic chan3_mask_enable, // 1 lets channel 3 through
	input wire logic chan2_polarity, // 0 inverts the counter-0 output
	input wire logic chan3_polarity, // 0 inverts the counter-2 output
	// Counter outputs that feed channels 2 and 3
	input wire logic counter0_output, // From counter 0
	input wire logic counter2_output, // From counter 2
	// Channels 0 and 1, already conditioned by the port-pin logic
	input wire logic irq_channel_zero, // Conditioned channel 0 from port logic
	input wire logic irq_channel_one, // Conditioned channel 1 from port logic
	// Counter inputs, channel status and the merged request
	output logic counter0_input, // To counter 0
	output logic counter1_input, // To counter 1
	output logic irq_channel_two, // Channel-2 status, after mask
	output logic irq_channel_three, // Channel-3 status, after mask
	output logic host_irq_b // Merged request, low while any channel is high
);
	// Registered state of the whole block; every output comes straight from a flop
	typedef struct packed {
		logic cnt0_in; // Counter-0 input
		logic cnt1_in; // Counter-1 clock, registered so a source swap lands on an edge
		logic ch2; // Masked channel 2
		logic ch3; // Masked channel 3
		logic irq_b; // Active-low request
		ticc_pkg::ticc_state_e st; // Request state
	} ticc_state_s;

	// Present and next copies of the state
	ticc_state_s s_q, s_d;
	logic fast_clk; // 2 MHz source
	logic slow_clk; // 32768 Hz source

	// Half period of the fast source, as a plain constant for the delay check below
	localparam int FAST_HALF_CYC = ticc_pkg::TICC_FAST_HALF;

	// Polarity and mask applied together; used for both counter channels
	function automatic logic ticc_cond(input logic src, input logic pol, input logic en);
		ticc_cond = en & (pol ? src : ~src);
	endfunction : ticc_cond

	// The two clock sources; both are approximate since neither half period is a whole number of mclk cycles
	// Both dividers restart from reset, so their phase is tied to the release of rst_b
	ticc_clkdiv #(.W(ticc_pkg::TICC_DIV_W)) u_fast (
		.mclk(mclk),
		.rst_b(rst_b),
		.half_cnt(ticc_pkg::TICC_DIV_W'(ticc_pkg::TICC_FAST_HALF)),
		.clk_out(fast_clk)
	);
	ticc_clkdiv #(.W(ticc_pkg::TICC_DIV_W)) u_slow (
		.mclk(mclk),
		.rst_b(rst_b),
		.half_cnt(ticc_pkg::TICC_DIV_W'(ticc_pkg::TICC_SLOW_HALF)),
		.clk_out(slow_clk)
	);

	// Next state of the conditioning paths
	always_comb begin
		s_d = s_q;
		// Counter-0 input: the pin level, complemented when the select bit is set
		s_d.cnt0_in = cnt0_input_polarity_sel ? ~port_c_bit0 : port_c_bit0;
		// Counter-1 clock: one of the two internal dividers
		s_d.cnt1_in = cnt1_clock_sel ? slow_clk : fast_clk;
		// Counter channels: polarity first, then the mask, so a blocked channel stays low
		s_d.ch2 = ticc_cond(counter0_output, chan2_polarity, chan2_mask_enable);
		s_d.ch3 = ticc_cond(counter2_output, chan3_polarity, chan3_mask_enable);
		// Equal-priority merge; simultaneous channels give one request
		case (s_q.st)
			ticc_pkg::TICC_IDLE: begin
				// Any channel high opens a request
				if (s_d.ch2 | s_d.ch3 | irq_channel_zero | irq_channel_one) begin
					s_d.st = ticc_pkg::TICC_REQ;
				end
			end
			ticc_pkg::TICC_REQ: begin
				// Held low as long as any source stays high; a steady source repeats
				if (!(s_d.ch2 | s_d.ch3 | irq_channel_zero | irq_channel_one)) begin
					s_d.st = ticc_pkg::TICC_IDLE;
				end
			end
			// Unused codes fall back to idle instead of locking the request
			default: s_d.st = ticc_pkg::TICC_IDLE;
		endcase
		// Decoded from the next state, so the pin adds no cycle beyond the channel flops
		s_d.irq_b = (s_d.st != ticc_pkg::TICC_REQ);
	end

	// State register
	always_ff @(posedge mclk) begin
		// Reset: counter inputs low, channels blocked, request released
		if (!rst_b) begin
			s_q.cnt0_in <= 1'h0;
			s_q.cnt1_in <= 1'h0;
			s_q.ch2 <= ticc_pkg::TICC_RST_MASK;
			s_q.ch3 <= ticc_pkg::TICC_RST_MASK;
			s_q.irq_b <= 1'h1;
			s_q.st <= ticc_pkg::TICC_IDLE;
		end else begin
			// Normal run: take the next state on every edge
			s_q <= s_d;
		end
	end

	// Outputs straight from the state register
	assign counter0_input = s_q.cnt0_in;
	assign counter1_input = s_q.cnt1_in;
	assign irq_channel_two = s_q.ch2;
	assign irq_channel_three = s_q.ch3;
	assign host_irq_b = s_q.irq_b;

	// Assertions; apart from the reset-value check, each attempt opens only on an edge that already saw reset released,
	// so the edge that ends reset never starts an attempt with stale inputs

	// Counter-0 input tracks the pin through the select bit
	property p_cnt0_in;
		@(posedge mclk) disable iff (!rst_b)
		rst_b |=> counter0_input == ($past(cnt0_input_polarity_sel) ^ $past(port_c_bit0));
	endproperty
	a_cnt0_in: assert property (p_cnt0_in) else $error("counter0 input wrong");

	// A blocked channel 2 stays low
	property p_ch2_mask;
		@(posedge mclk) disable iff (!rst_b)
		rst_b && !chan2_mask_enable |=> !irq_channel_two;
	endproperty
	a_ch2_mask: assert property (p_ch2_mask) else $error("channel 2 not blocked");

	// An enabled channel 2 follows or inverts counter 0
	property p_ch2_pol;
		@(posedge mclk) disable iff (!rst_b)
		rst_b && chan2_mask_enable |=>
			irq_channel_two == ($past(chan2_polarity) ~^ $past(counter0_output));
	endproperty
	a_ch2_pol: assert property (p_ch2_pol) else $error("channel 2 polarity wrong");

	// A blocked channel 3 stays low
	property p_ch3_mask;
		@(posedge mclk) disable iff (!rst_b)
		rst_b && !chan3_mask_enable |=> !irq_channel_three;
	endproperty
	a_ch3_mask: assert property (p_ch3_mask) else $error("channel 3 not blocked");

	// Channel-3 polarity zero inverts counter 2
	property p_ch3_pol;
		@(posedge mclk) disable iff (!rst_b)
		rst_b && chan3_mask_enable && !chan3_polarity |=>
			irq_channel_three == !$past(counter2_output);
	endproperty
	a_ch3_pol: assert property (p_ch3_pol) else $error("channel 3 polarity wrong");

	// Channel-3 polarity one passes counter 2 unchanged
	property p_ch3_plain;
		@(posedge mclk) disable iff (!rst_b)
		rst_b && chan3_mask_enable && chan3_polarity |=>
			irq_channel_three == $past(counter2_output);
	endproperty
	a_ch3_plain: assert property (p_ch3_plain) else $error("channel 3 plain wrong");

	// Select one routes the slow source to counter 1
	property p_clk_sel;
		@(posedge mclk) disable iff (!rst_b)
		rst_b && cnt1_clock_sel |=> counter1_input == $past(slow_clk);
	endproperty
	a_clk_sel: assert property (p_clk_sel) else $error("counter1 clock source wrong");

	// Select zero routes the fast source to counter 1
	property p_clk_fast;
		@(posedge mclk) disable iff (!rst_b)
		rst_b && !cnt1_clock_sel |=> counter1_input == $past(fast_clk);
	endproperty
	a_clk_fast: assert property (p_clk_fast) else $error("counter1 fast source wrong");

	// The fast source toggles once per half period, checked two edges clear of reset
	sequence s_fast_edge;
		rst_b && $past(rst_b) && $changed(fast_clk);
	endsequence
	property p_fast_half;
		@(posedge mclk) disable iff (!rst_b)
		s_fast_edge |-> ##FAST_HALF_CYC $changed(fast_clk);
	endproperty
	a_fast_half: assert property (p_fast_half) else $error("fast source period wrong");

	// Any channel high pulls the merged request low
	sequence s_any_src;
		irq_channel_two || irq_channel_three || $past(irq_channel_zero) || $past(irq_channel_one);
	endsequence
	property p_irq_low;
		@(posedge mclk) disable iff (!rst_b)
		rst_b ##1 s_any_src |-> !host_irq_b;
	endproperty
	a_irq_low: assert property (p_irq_low) else $error("request not asserted");

	// The request is never low without a channel behind it
	property p_irq_high;
		@(posedge mclk) disable iff (!rst_b)
		rst_b ##1 !host_irq_b |-> (irq_channel_two || irq_channel_three ||
			$past(irq_channel_zero) || $past(irq_channel_one));
	endproperty
	a_irq_high: assert property (p_irq_high) else $error("request without source");

	// Reset values; this one deliberately has no reset disable
	property p_rst_vals;
		@(posedge mclk)
		!rst_b |=> !counter0_input && !counter1_input && !irq_channel_two &&
			!irq_channel_three && host_irq_b;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset values wrong");
endmodule : ticc_top
`default_nettype wire

// *** hdl/ticc_pkg.sv ***
// Constants shared by the counter interrupt channel conditioning block.
// Assumes a single 250 MHz clock and a synchronous active-low reset.
`default_nettype none
package ticc_pkg;
	// Reset values of the control bits: channels blocked, polarity inverted
	localparam logic TICC_RST_MASK = 1'h0;
	localparam logic TICC_RST_POL = 1'h0;
	localparam logic TICC_RST_SEL = 1'h0;
	// Board clock figures
	localparam int TICC_MCLK_HZ = 250000000;
	localparam int TICC_FAST_HZ = 2000000;
	localparam int TICC_SLOW_HZ = 32768;
	// Half periods of the counter-1 clock sources, in mclk cycles
	localparam int TICC_FAST_HALF = TICC_MCLK_HZ / (2 * TICC_FAST_HZ);
	localparam int TICC_SLOW_HALF = TICC_MCLK_HZ / (2 * TICC_SLOW_HZ);
	// Width of the clock divider counter
	localparam int TICC_DIV_W = 12;
	// Request state encoding
	typedef enum logic [1:0] {
		TICC_IDLE = 2'h0,
		TICC_REQ = 2'h1
	} ticc_state_e;
endpackage : ticc_pkg
`default_nettype wire

// *** hdl/ticc_clkdiv.sv ***
// Square wave generator: toggles its output every half_cnt mclk cycles.
// Assumes half_cnt is at least one and stable while running.
`timescale 1ns/1ps
`default_nettype none
module ticc_clkdiv #(
	parameter int W = ticc_pkg::TICC_DIV_W
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [W-1:0] half_cnt,
	output logic clk_out
);
	typedef struct packed {
		logic [W-1:0] cnt; // Cycles spent in the current half period
		logic lvl; // Output level
	} ticc_div_s;
	ticc_div_s s_q, s_d;

	// Next state: toggle at the end of each half period
	always_comb begin
		s_d = s_q;
		if (s_q.cnt >= half_cnt - W'(1)) begin
			s_d.cnt = '0;
			s_d.lvl = ~s_q.lvl;
		end else begin
			s_d.cnt = s_q.cnt + W'(1);
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign clk_out = s_q.lvl;
endmodule : ticc_clkdiv
`default_nettype wire

// *** tb/ticc_host_model.sv ***
// Host side of the merged request: counts the interrupts that it would service.
// Assumes host_irq_b is synchronous to mclk.
`timescale 1ns/1ps
`default_nettype none
module ticc_host_model #(
	parameter int RETRIG = 16 // Cycles between re-entries while the line is held low
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic host_irq_b,
	output var int irq_taken
);
	int run_q; // Cycles since the last entry in the present low level
	// A fresh low level is taken at once; a held level re-enters every RETRIG cycles
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			run_q <= 0;
			irq_taken <= 0;
		end else if (!host_irq_b) begin
			run_q <= (run_q == RETRIG - 1) ? 0 : run_q + 1;
			if (run_q == 0) irq_taken <= irq_taken + 1;
		end else begin
			run_q <= 0;
		end
	end
endmodule : ticc_host_model
`default_nettype wire

// *** tb/ticc_top_test.sv ***
// Self-checking bench for the counter interrupt channel conditioning block.
// Assumes the host model counts serviced interrupts off the merged request.
`timescale 1ns/1ps
`default_nettype none
module ticc_top_test;
	logic mclk = 1'h0; // 250 MHz board clock
	logic rst_b = 1'h0; // Held low for the first 12 cycles
	logic sel_q = 1'h0; // Counter-1 clock select
	logic [9:0] in_q = 10'h3FC; // pin sel mask2 pol2 c0 mask3 pol3 c2 ch0 ch1
	logic c0_in, c1_in, ch2, ch3, host_irq_b;
	// Rows: inputs, then counter0_input, channel 2, channel 3, host_irq_b
	logic [13:0] rows [7] = '{14'h0001, 14'h280C, 14'h3D41, 14'h1FCE, 14'h0702, 14'h0020, 14'h0010};
	int error_cnt = 0, cmp_count = 0, n, t0, taken;
	initial forever #2 mclk = ~mclk;
	ticc_top i_dut (.mclk(mclk), .rst_b(rst_b), .port_c_bit0(in_q[9]),
		.cnt0_input_polarity_sel(in_q[8]), .cnt1_clock_sel(sel_q),
		.chan2_mask_enable(in_q[7]), .chan2_polarity(in_q[6]), .counter0_output(in_q[5]),
		.chan3_mask_enable(in_q[4]), .chan3_polarity(in_q[3]), .counter2_output(in_q[2]),
		.irq_channel_zero(in_q[1]), .irq_channel_one(in_q[0]), .counter0_input(c0_in),
		.counter1_input(c1_in), .irq_channel_two(ch2), .irq_channel_three(ch3),
		.host_irq_b(host_irq_b));
	ticc_host_model i_host (.mclk(mclk), .rst_b(rst_b), .host_irq_b(host_irq_b), .irq_taken(taken));
	task automatic chk(input string nm, input logic e, input logic g);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk
	task automatic chk_n(input string nm, input int e, input int g);
		cmp_count++;
		if (g != e) begin
			error_cnt++;
			$display("[FAIL] %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_n
	task automatic summarize;
		$display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	// Apply inputs at an edge, then sample once the registered outputs settle
	task automatic drive(input logic [9:0] v, input int cyc);
		@(posedge mclk);
		in_q <= v;
		repeat (cyc) @(posedge mclk);
		#1;
	endtask : drive
	// Cycles until counter1_input next toggles; a missing toggle ends the run
	task automatic meas(output int k);
		logic v;
		v = c1_in;
		k = 0;
		while (c1_in === v && k < 5000) begin
			@(posedge mclk);
			#1;
			k++;
		end
		if (k >= 5000) begin
			error_cnt++;
			$display("[FAIL] counter1_input expected toggle seen none");
			summarize();
		end
	endtask : meas
	// Main sequence: reset, table rows, host pulses, mid-run reset, then clock source periods
	initial begin
		repeat (11) @(posedge mclk);
		#1;
		chk("reset counter0_input", 1'h0, c0_in);
		chk("reset irq_channel_two", 1'h0, ch2);
		chk("reset irq_channel_three", 1'h0, ch3);
		chk("reset host_irq_b", 1'h1, host_irq_b);
		chk("reset counter1_input", 1'h0, c1_in);
		@(posedge mclk);
		rst_b <= 1'h1;
		in_q <= 10'h000;
		$display("Test reset done");
		foreach (rows[i]) begin
			drive(rows[i][13:4], 2);
			chk("counter0_input", rows[i][3], c0_in);
			chk("irq_channel_two", rows[i][2], ch2);
			chk("irq_channel_three", rows[i][1], ch3);
			chk("host_irq_b", rows[i][0], host_irq_b);
		end
		$display("Test table done");
		// Sources idle low and request with short high pulses; the line must idle first
		drive(10'h000, 4);
		t0 = taken;
		drive(10'h002, 0);
		drive(10'h000, 4);
		chk_n("one pulse interrupts", t0 + 1, taken);
		drive(10'h003, 0);
		drive(10'h000, 4);
		chk_n("merged pulse interrupts", t0 + 2, taken);
		drive(10'h002, 19);
		drive(10'h000, 4);
		chk_n("held low interrupts", t0 + 4, taken);
		$display("Test host done");
		// Reset in mid-run with counter0_input and channels 2 and 3 active, then the first edge after release
		drive(10'h1FC, 2);
		chk("busy host_irq_b", 1'h0, host_irq_b);
		@(posedge mclk);
		rst_b <= 1'h0;
		repeat (2) @(posedge mclk);
		#1;
		chk("rerun counter0_input", 1'h0, c0_in);
		chk("rerun irq_channel_two", 1'h0, ch2);
		chk("rerun irq_channel_three", 1'h0, ch3);
		chk("rerun host_irq_b", 1'h1, host_irq_b);
		chk("rerun counter1_input", 1'h0, c1_in);
		@(posedge mclk);
		rst_b <= 1'h1;
		@(posedge mclk);
		#1;
		chk("released counter0_input", 1'h1, c0_in);
		chk("released irq_channel_two", 1'h1, ch2);
		chk("released irq_channel_three", 1'h1, ch3);
		chk("released host_irq_b", 1'h0, host_irq_b);
		drive(10'h000, 4);
		$display("Test rerun done");
		meas(n);
		meas(n);
		meas(n);
		chk_n("fast half period", ticc_pkg::TICC_FAST_HALF, n);
		@(posedge mclk);
		sel_q <= 1'h1;
		meas(n);
		meas(n);
		meas(n);
		chk_n("slow half period", ticc_pkg::TICC_SLOW_HALF, n);
		$display("Test clock done");
		summarize();
	end
endmodule : ticc_top_test
`default_nettype wire
